// *** hw/scp_reader.sv ***
// Read side of a one-time-programmable serial configuration memory.
`timescale 1ns/1ps

// Operation
// - chain_enable_out_n feeds next memory chip enable; clock, data shared.
// - Chip enable held active keeps data output driven until the clock after the last bit.
// - Bits leave in order, counter advancing per qualified clock rise.
// - Address counter resets at power-up.
// - With output enable tied active, counter survives completed loads.
// - Apart from power-up reset, only the reset level on reset/output-enable clears the counter.
// - Clock after last bit drives chain enable low, data high-Z.
// - Downstream memory drives data when its chip enable goes low.
// - Active-low reset polarity lets loader reset clear every counter.
// - Reset level holds counter at zero and data output high-Z.
// - After full read chain enable follows chip enable; stays high if off.
// - Chip enable high freezes counter, releases data, enters standby.
// - Counter stops at terminal count, data released, chain enable low.
module scp_reader (
   input wire logic clock,               // 20 MHz system clock
   input wire logic reset,               // synchronous active-high reset
   input wire logic config_clock,        // configuration clock pin
   input wire logic chip_enable_n,       // chip enable pin, active low
   input wire logic reset_oe,            // reset/output-enable pin
   input wire logic reset_active_low,    // polarity option: 1 = active low
   input wire logic load_valid,          // image load word valid
   output logic load_ready,              // image load may accept
   input wire logic [scp_pkg::WORD_AW-1:0] load_addr, // image word address
   input wire logic [scp_pkg::WORD_W-1:0] load_data,  // image word
   output logic data_out,                // serial data pin level
   output logic data_oe,                 // serial data pin drive enable
   output logic chain_enable_out_n,      // chain enable output, active low
   output logic standby,                 // low-power standby indicator
   output logic [scp_pkg::ADDR_W-1:0] bit_address // current bit address
);
   // ****************************************************************
   // Pin synchronisers
   // ****************************************************************
   logic clk_rise;
   logic ce_n_s;
   logic roe_s;
   logic pol_s;

   scp_sync u_sync_clk (
      .clock(clock),
      .reset(reset),
      .async_in(config_clock),
      .level_out(),
      .rise_out(clk_rise)
   );

   scp_sync u_sync_ce (
      .clock(clock),
      .reset(reset),
      .async_in(chip_enable_n),
      .level_out(ce_n_s),
      .rise_out()
   );

   scp_sync u_sync_roe (
      .clock(clock),
      .reset(reset),
      .async_in(reset_oe),
      .level_out(roe_s),
      .rise_out()
   );

   scp_sync u_sync_pol (
      .clock(clock),
      .reset(reset),
      .async_in(reset_active_low),
      .level_out(pol_s),
      .rise_out()
   );

   // ****************************************************************
   // Synchroniser settling
   // ****************************************************************
   // The synchroniser flops leave reset low, which would read as a
   // selected chip with outputs enabled for two cycles. Until both stages
   // have seen the real pin levels the memory counts as deselected and
   // held in reset, so no false select follows a power-up reset.
   logic [1:0] settle_ff;
   logic [1:0] nxt_settle;
   logic settled;

   always_comb begin
      nxt_settle = {settle_ff[0], 1'b1};
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         settle_ff <= 2'h0;
      end else begin
         settle_ff <= nxt_settle;
      end
   end

   assign settled = settle_ff[1];

   scp_pkg::scp_ctl_t ctl;
   logic rst_level;
   logic pin_rst;

   always_comb begin
      // The pin is a reset at one level and an output enable at the other.
      pin_rst = pol_s ? ~roe_s : roe_s;
      rst_level = pin_rst | ~settled;
      ctl.clk_rise = clk_rise;
      ctl.chip_en = ~ce_n_s & settled;
      ctl.out_en = ~rst_level;
   end

   // ****************************************************************
   // Image storage
   // ****************************************************************
   // depth parameter
   logic [scp_pkg::WORD_W-1:0] image_mem [scp_pkg::WORD_CNT];

   always_ff @(posedge clock) begin
      if (load_valid && load_ready) begin
         image_mem[load_addr] <= load_data;
      end
   end

   // ****************************************************************
   // Address counter and state
   // ****************************************************************
   scp_pkg::scp_state_t state_ff;
   scp_pkg::scp_state_t nxt_state;
   logic [scp_pkg::ADDR_W-1:0] addr_ff;
   logic [scp_pkg::ADDR_W-1:0] nxt_addr;
   logic ceo_lock_ff;
   logic nxt_ceo_lock;
   // Set once the terminal bit has been pushed; the counter itself never
   // moves past the terminal count.
   logic last_ff;
   logic nxt_last;
   logic fifo_in_ready;
   logic fifo_push;
   logic cur_bit;
   logic [scp_pkg::BIT_AW-1:0] bit_sel;

   assign bit_sel = addr_ff[scp_pkg::BIT_AW-1:0];
   assign cur_bit = image_mem[addr_ff[scp_pkg::ADDR_W-1:scp_pkg::BIT_AW]]
                    [bit_sel];

   always_comb begin
      nxt_state = state_ff;
      nxt_addr = addr_ff;
      nxt_ceo_lock = ceo_lock_ff;
      nxt_last = last_ff;
      fifo_push = 1'b0;
      case (state_ff)
         scp_pkg::SCP_IDLE: begin
            if (ctl.chip_en && ctl.out_en) begin
               nxt_state = scp_pkg::SCP_READ;
            end
         end
         scp_pkg::SCP_READ: begin
            if (!ctl.chip_en || !ctl.out_en) begin
               nxt_state = scp_pkg::SCP_IDLE;
            // The last bit is pushed on one rise and the pin is only
            // released on the rise after, so the loader can sample it.
            end else if (ctl.clk_rise && last_ff) begin
               nxt_state = scp_pkg::SCP_DONE;
            end else if (ctl.clk_rise && fifo_in_ready) begin
               fifo_push = 1'b1;
               if (addr_ff == scp_pkg::TERMINAL_COUNT) begin
                  nxt_last = 1'b1;
               end else begin
                  nxt_addr = scp_pkg::ADDR_W'(addr_ff + 1'b1);
               end
            end
         end
         scp_pkg::SCP_DONE: begin
            if (!ctl.out_en) begin
               nxt_ceo_lock = 1'b1;
            end
         end
         default: begin
            nxt_state = scp_pkg::SCP_IDLE;
         end
      endcase
      if (rst_level) begin
         nxt_state = scp_pkg::SCP_IDLE;
         nxt_addr = scp_pkg::ADDR_RESET;
         nxt_ceo_lock = 1'b0;
         nxt_last = 1'b0;
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         state_ff <= scp_pkg::SCP_IDLE;
         addr_ff <= scp_pkg::ADDR_RESET;
         ceo_lock_ff <= 1'b0;
         last_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         addr_ff <= nxt_addr;
         ceo_lock_ff <= nxt_ceo_lock;
         last_ff <= nxt_last;
      end
   end

   // ****************************************************************
   // Output bit buffer
   // ****************************************************************
   // Each bit enters the buffer on its qualified rise and reaches the pin
   // on the next system clock, so the pin shows the bit that the counter has
   // just left, or the terminal bit where the counter stops. The buffer decouples the image read from the
   // pin stage at the cost of one clock of extra latency.
   logic fifo_valid;
   logic fifo_data;
   logic fifo_pop;
   logic fifo_flush;

   // A bit still in flight when the part is deselected is lost; a loader
   // only deselects between frames, when the buffer is already empty.
   assign fifo_flush = rst_level | ~ctl.chip_en;
   assign fifo_pop = fifo_valid;

   scp_fifo #(
      .WIDTH(1),
      .DEPTH(scp_pkg::FIFO_DEPTH)
   ) u_fifo (
      .clock(clock),
      .reset(reset),
      .flush(fifo_flush),
      .in_valid(fifo_push),
      .in_ready(fifo_in_ready),
      .in_data(cur_bit),
      .out_valid(fifo_valid),
      .out_ready(fifo_pop),
      .out_data(fifo_data)
   );

   // ****************************************************************
   // Pin outputs
   // ****************************************************************
   scp_pkg::scp_pins_t pins_ff;
   scp_pkg::scp_pins_t nxt_pins;
   logic done;

   assign done = (state_ff == scp_pkg::SCP_DONE);

   always_comb begin
      nxt_pins.data_out = pins_ff.data_out;
      if (fifo_pop) begin
         nxt_pins.data_out = fifo_data;
      end
      // Data is driven as soon as the part is selected, before the first
      // rise, so the loader never samples a floating line.
      // drive while selected
      nxt_pins.data_oe = ctl.chip_en & ctl.out_en & ~done;
      nxt_pins.chain_enable_out_n = ~(done & ctl.chip_en & ctl.out_en
                                      & ~ceo_lock_ff);
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         pins_ff <= '{data_out: 1'b0, data_oe: 1'b0,
                      chain_enable_out_n: 1'b1};
      end else begin
         pins_ff <= nxt_pins;
      end
   end

   assign data_out = pins_ff.data_out;
   assign data_oe = pins_ff.data_oe;
   assign chain_enable_out_n = pins_ff.chain_enable_out_n;
   assign standby = ~ctl.chip_en;
   assign bit_address = addr_ff;
   // Loading is only safe while the stream is idle and unselected.
   assign load_ready = ~ctl.chip_en;
endmodule

// *** hw/scp_pkg.sv ***
// Shared constants and types for the serial configuration memory reader.
package scp_pkg;

   // ****************************************************************
   // Geometry
   // ****************************************************************
   localparam int unsigned DEPTH_BITS = 65536;
   localparam int unsigned ADDR_W = $clog2(DEPTH_BITS);
   localparam int unsigned WORD_W = 8;
   localparam int unsigned WORD_CNT = DEPTH_BITS / WORD_W;
   localparam int unsigned WORD_AW = $clog2(WORD_CNT);
   localparam int unsigned BIT_AW = $clog2(WORD_W);
   localparam int unsigned FIFO_DEPTH = 16;
   localparam logic [ADDR_W-1:0] TERMINAL_COUNT = ADDR_W'(DEPTH_BITS - 1);
   localparam logic [ADDR_W-1:0] ADDR_RESET = '0;

   // ****************************************************************
   // Timing
   // ****************************************************************
   localparam int unsigned CLK_PERIOD_NS = 50;
   localparam int unsigned SYNC_STAGES = 2;

   // ****************************************************************
   // Types
   // ****************************************************************
   typedef enum logic [1:0] {
      SCP_IDLE,
      SCP_READ,
      SCP_DONE
   } scp_state_t;

   typedef struct packed {
      logic clk_rise;
      logic chip_en;
      logic out_en;
   } scp_ctl_t;

   typedef struct packed {
      logic data_out;
      logic data_oe;
      logic chain_enable_out_n;
   } scp_pins_t;

endpackage

// *** hw/scp_sync.sv ***
// Two-stage synchroniser with edge detect on the second stage output.
`timescale 1ns/1ps
module scp_sync (
   input wire logic clock,        // system clock
   input wire logic reset,        // synchronous active-high reset
   input wire logic async_in,     // pin level from outside
   output logic level_out,        // synchronised level
   output logic rise_out          // one-cycle pulse on rising edge
);
   logic meta_ff;
   logic sync_ff;
   logic prev_ff;
   logic nxt_meta;
   logic nxt_sync;
   logic nxt_prev;

   always_comb begin
      nxt_meta = async_in;
      nxt_sync = meta_ff;
      nxt_prev = sync_ff;
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         meta_ff <= 1'b0;
         sync_ff <= 1'b0;
         prev_ff <= 1'b0;
      end else begin
         meta_ff <= nxt_meta;
         sync_ff <= nxt_sync;
         prev_ff <= nxt_prev;
      end
   end

   assign level_out = sync_ff;
   assign rise_out = sync_ff & ~prev_ff;
endmodule

// *** hw/scp_fifo.sv ***
// Parameterised synchronous FIFO with valid/ready on both sides.
`timescale 1ns/1ps
module scp_fifo #(
   parameter int unsigned WIDTH = 1,
   parameter int unsigned DEPTH = 16
) (
   input wire logic clock,              // system clock
   input wire logic reset,              // synchronous active-high reset
   input wire logic flush,              // drop all contents
   input wire logic in_valid,           // write request
   output logic in_ready,               // space available
   input wire logic [WIDTH-1:0] in_data, // write data
   output logic out_valid,              // data available
   input wire logic out_ready,          // read accept
   output logic [WIDTH-1:0] out_data    // read data
);
   localparam int unsigned AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_ff [DEPTH];
   logic [AW-1:0] wr_ff;
   logic [AW-1:0] rd_ff;
   logic [AW:0] cnt_ff;
   logic [AW-1:0] nxt_wr;
   logic [AW-1:0] nxt_rd;
   logic [AW:0] nxt_cnt;
   logic push;
   logic pop;

   always_comb begin
      in_ready = (cnt_ff != (AW+1)'(DEPTH));
      out_valid = (cnt_ff != '0);
      push = in_valid & in_ready;
      pop = out_valid & out_ready;
      nxt_wr = push ? AW'(wr_ff + 1'b1) : wr_ff;
      nxt_rd = pop ? AW'(rd_ff + 1'b1) : rd_ff;
      nxt_cnt = cnt_ff;
      if (push && !pop) begin
         nxt_cnt = (AW+1)'(cnt_ff + 1'b1);
      end else if (pop && !push) begin
         nxt_cnt = (AW+1)'(cnt_ff - 1'b1);
      end
      if (flush) begin
         nxt_wr = '0;
         nxt_rd = '0;
         nxt_cnt = '0;
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         wr_ff <= '0;
         rd_ff <= '0;
         cnt_ff <= '0;
      end else begin
         wr_ff <= nxt_wr;
         rd_ff <= nxt_rd;
         cnt_ff <= nxt_cnt;
      end
   end

   // Storage needs no reset; only the pointers qualify it.
   always_ff @(posedge clock) begin
      if (push && !flush) begin
         mem_ff[wr_ff] <= in_data;
      end
   end

   assign out_data = mem_ff[rd_ff];
endmodule

// *** sim/scp_reader_assertions.sv ***
// Concurrent checks on the ports of the serial memory reader.
`timescale 1ns/1ps
module scp_reader_assertions (
   input wire logic clock, // system clock
   input wire logic reset, // synchronous reset
   input wire logic chip_enable_n, // chip enable pin
   input wire logic reset_oe, // reset/output-enable pin
   input wire logic reset_active_low, // reset polarity option
   input wire logic standby, // standby flag
   input wire logic load_ready, // load space flag
   input wire logic data_oe, // data drive enable
   input wire logic chain_enable_out_n, // chain enable output
   input wire logic [scp_pkg::ADDR_W-1:0] bit_address // bit counter
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (reset);

   // ******************************
   // Checks
   // ******************************
   a_reset_state: assert property ($fell(reset) |-> !data_oe &&
      chain_enable_out_n && bit_address == '0)
      else $error("outputs not in reset state after reset");
   a_freeze_addr: assert property (standby && $past(standby) |->
      bit_address == $past(bit_address) || bit_address == '0)
      else $error("counter moved while deselected");
   a_standby_hiz: assert property (standby && $past(standby) |->
      !data_oe)
      else $error("data driven in standby");
   a_ready_match: assert property (!load_ready |->
      !$past(chip_enable_n, 2) && !standby)
      else $error("load ready low while chip not selected");
   a_addr_step: assert property ($changed(bit_address) |->
      bit_address == $past(bit_address) + 1 || bit_address == '0)
      else $error("counter jumped");
   a_tc_stop: assert property (bit_address == scp_pkg::TERMINAL_COUNT
      |=> bit_address == scp_pkg::TERMINAL_COUNT || bit_address == '0)
      else $error("counter passed terminal count");
   a_chain_hiz: assert property (!chain_enable_out_n |-> !data_oe)
      else $error("data driven with chain enable low");
   a_chain_ce: assert property (standby && $past(standby) |->
      chain_enable_out_n)
      else $error("chain enable low while deselected");
   a_zero_hiz: assert property ((reset_oe != reset_active_low)[*4]
      |-> bit_address == '0 && !data_oe)
      else $error("counter or data not held while reset level");
endmodule

// *** sim/scp_loader_model.sv ***
// Behavioural loader that clocks the memory and samples its data line.
`timescale 1ns/1ps
module scp_loader_model (
   input wire logic clock, // system clock
   input wire logic data_out, // memory data level
   input wire logic data_oe, // memory drive enable
   output logic config_clock // configuration clock to the memory
);
   logic got_q[$];
   logic line;

   // The clock stands low between frames, as the loader only runs it
   // while it is loading.
   initial config_clock = 1'b0;

   assign line = data_oe ? data_out : 1'b1;

   task automatic pulse(input int n);
      repeat (n) begin
         config_clock = 1'b1;
         repeat (6) @(negedge clock);
         got_q.push_back(line);
         config_clock = 1'b0;
         repeat (6) @(negedge clock);
      end
   endtask
endmodule

// *** sim/test_scp_reader.sv ***
// Self-checking bench for the serial memory reader.
`timescale 1ns/1ps
module test_scp_reader;
   logic clock = 1'b0;
   logic reset = 1'b1;
   logic config_clock;
   logic chip_enable_n = 1'b1;
   logic reset_oe = 1'b1;
   logic reset_active_low = 1'b1;
   logic load_valid = 1'b0;
   logic load_ready;
   logic [scp_pkg::WORD_AW-1:0] load_addr = '0;
   logic [scp_pkg::WORD_W-1:0] load_data = '0;
   logic data_out, data_oe, chain_enable_out_n, standby;
   logic [scp_pkg::ADDR_W-1:0] bit_address;
   logic [7:0] img [4];
   int errors = 0;
   int n_checks = 0;

   initial begin
      forever #25 clock = ~clock;
   end

   scp_reader i_scp_reader (.clock(clock), .reset(reset),
      .config_clock(config_clock), .chip_enable_n(chip_enable_n),
      .reset_oe(reset_oe), .reset_active_low(reset_active_low),
      .load_valid(load_valid), .load_ready(load_ready),
      .load_addr(load_addr), .load_data(load_data), .data_out(data_out),
      .data_oe(data_oe), .chain_enable_out_n(chain_enable_out_n),
      .standby(standby), .bit_address(bit_address));
   scp_loader_model i_scp_loader_model (.clock(clock),
      .data_out(data_out), .data_oe(data_oe), .config_clock(config_clock));

   // ******************************
   // Tasks
   // ******************************
   task automatic check(input string what, input logic [15:0] seen,
      input logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic load_all();
      for (int k = 0; k < 4; k++) begin
         load_addr = k[scp_pkg::WORD_AW-1:0];
         load_data = img[k];
         load_valid = 1'b1;
         @(negedge clock);
      end
      load_valid = 1'b0;
   endtask

   // Pins pass a synchroniser, so settle before looking.
   task automatic settle();
      repeat (6) @(negedge clock);
   endtask

   task automatic read_bits(input int n, input int first);
      int b;
      logic e;
      i_scp_loader_model.got_q.delete();
      i_scp_loader_model.pulse(n);
      for (int i = 0; i < n; i++) begin
         b = first + i;
         e = img[b / 8][b % 8];
         check("data bit", 16'(i_scp_loader_model.got_q[i]), 16'(e));
      end
   endtask

   task automatic tally_and_finish();
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // ******************************
   // Sequence
   // ******************************
   initial begin
      for (int k = 0; k < 4; k++) img[k] = 8'h5a ^ 8'(k * 37);
      repeat (4) @(negedge clock);
      reset = 1'b0;
      settle();
      check("oe", 16'(data_oe), 16'h0);
      check("chain", 16'(chain_enable_out_n), 16'h1);
      check("addr", bit_address, 16'h0);
      check("ready", 16'(load_ready), 16'h1);
      load_all();
      $display("test reset_and_load done");
      chip_enable_n = 1'b0;
      settle();
      check("standby", 16'(standby), 16'h0);
      read_bits(16, 0);
      check("addr", bit_address, 16'h10);
      check("oe", 16'(data_oe), 16'h1);
      $display("test first_read done");
      chip_enable_n = 1'b1;
      settle();
      check("oe", 16'(data_oe), 16'h0);
      check("standby", 16'(standby), 16'h1);
      i_scp_loader_model.pulse(4);
      check("addr", bit_address, 16'h10);
      chip_enable_n = 1'b0;
      settle();
      read_bits(8, 16);
      check("addr", bit_address, 16'h18);
      $display("test deselect_resume done");
      for (int p = 0; p < 2; p++) begin
         reset_active_low = (p == 0);
         reset_oe = (p != 0);
         settle();
         i_scp_loader_model.pulse(2);
         check("addr", bit_address, 16'h0);
         check("oe", 16'(data_oe), 16'h0);
         reset_oe = ~reset_oe;
         settle();
         read_bits(8, 0);
         check("addr", bit_address, 16'h8);
         $display("test reset_polarity %0d done", p);
      end
      tally_and_finish();
   end

   initial begin
      repeat (20000) @(posedge clock);
      errors++;
      tally_and_finish();
   end
endmodule

bind scp_reader scp_reader_assertions i_scp_reader_assertions (
   .clock(clock), .reset(reset), .standby(standby),
   .chip_enable_n(chip_enable_n), .reset_oe(reset_oe),
   .reset_active_low(reset_active_low),
   .load_ready(load_ready), .data_oe(data_oe),
   .chain_enable_out_n(chain_enable_out_n), .bit_address(bit_address));
